// *** rtl/addr_mode_pkg.sv ***
// constants, opcodes and types shared by the addressing-mode decoder
package addr_mode_pkg;

  // ----------------------------------------------------------------
  // data path widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam logic [15:0] RESET_PC = 16'h0100;
  localparam logic [7:0] ZERO_PAGE = 8'h00;

  // ----------------------------------------------------------------
  // addressing modes, taken from the opcode high nibble
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_INH = 3'h0,
    MODE_IMM = 3'h1,
    MODE_DIR = 3'h2,
    MODE_EXT = 3'h3,
    MODE_IX  = 3'h4,
    MODE_IX1 = 3'h5,
    MODE_IX2 = 3'h6,
    MODE_REL = 3'h7
  } mode_t;

  localparam logic [3:0] HI_REL = 4'h2;
  localparam logic [3:0] HI_IMM = 4'ha;
  localparam logic [3:0] HI_DIR = 4'hb;
  localparam logic [3:0] HI_EXT = 4'hc;
  localparam logic [3:0] HI_IX2 = 4'hd;
  localparam logic [3:0] HI_IX1 = 4'he;
  localparam logic [3:0] HI_IX = 4'hf;

  // ----------------------------------------------------------------
  // register/memory operations, opcode low nibble
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_SUB = 4'h0;
  localparam logic [3:0] OP_CMP = 4'h1;
  localparam logic [3:0] OP_SBC = 4'h2;
  localparam logic [3:0] OP_CPX = 4'h3;
  localparam logic [3:0] OP_AND = 4'h4;
  localparam logic [3:0] OP_BIT = 4'h5;
  localparam logic [3:0] OP_LDA = 4'h6;
  localparam logic [3:0] OP_STA = 4'h7;
  localparam logic [3:0] OP_EOR = 4'h8;
  localparam logic [3:0] OP_ADC = 4'h9;
  localparam logic [3:0] OP_ORA = 4'ha;
  localparam logic [3:0] OP_ADD = 4'hb;
  localparam logic [3:0] OP_LDX = 4'he;
  localparam logic [3:0] OP_STX = 4'hf;

  // ----------------------------------------------------------------
  // branch conditions, opcode low nibble of relative group
  // ----------------------------------------------------------------
  localparam logic [3:0] BR_ALWAYS = 4'h0;
  localparam logic [3:0] BR_NEVER = 4'h1;
  localparam logic [3:0] BR_CARRY_CLR = 4'h4;
  localparam logic [3:0] BR_CARRY_SET = 4'h5;
  localparam logic [3:0] BR_NOT_EQUAL = 4'h6;
  localparam logic [3:0] BR_EQUAL = 4'h7;
  localparam logic [3:0] BR_PLUS = 4'ha;
  localparam logic [3:0] BR_MINUS = 4'hb;

  // ----------------------------------------------------------------
  // inherent opcodes handled here
  // ----------------------------------------------------------------
  localparam logic [7:0] UNSIGNED_MULTIPLY_OP = 8'h42;
  localparam logic [7:0] ACCUMULATOR_INCREMENT_OP = 8'h4c;
  localparam logic [7:0] CARRY_CLEAR_OP = 8'h98;
  localparam logic [7:0] CARRY_SET_OP = 8'h99;
  localparam logic [7:0] ACC_TO_IDX_OP = 8'h97;
  localparam logic [7:0] IDX_TO_ACC_OP = 8'h9f;

  localparam int INSTR_COUNT = 62;
  localparam int MODE_COUNT = 8;

endpackage : addr_mode_pkg

// *** rtl/operand_address_unit.sv ***
// effective address and branch target arithmetic
`timescale 1ns/100ps
module operand_address_unit (
  input wire logic [2:0] mode,
  input wire logic [7:0] idx,
  input wire logic [7:0] byte1,
  input wire logic [7:0] byte2,
  input wire logic [15:0] pc,
  output logic [15:0] effAddr,
  output logic [15:0] branchTarget
);

  // ----------------------------------------------------------------
  // operand address per mode
  // ----------------------------------------------------------------
  wire [15:0] dirAddr = {addr_mode_pkg::ZERO_PAGE, byte1};
  wire [15:0] extAddr = {byte1, byte2};
  wire [15:0] ixAddr = {addr_mode_pkg::ZERO_PAGE, idx};
  wire [15:0] ix1Addr = {7'h00, {1'b0, idx} + {1'b0, byte1}};
  wire [15:0] ix2Addr = {byte1, byte2} + {8'h00, idx};

  assign effAddr = (mode == 3'(addr_mode_pkg::MODE_DIR)) ? dirAddr :
                   (mode == 3'(addr_mode_pkg::MODE_EXT)) ? extAddr :
                   (mode == 3'(addr_mode_pkg::MODE_IX)) ? ixAddr :
                   (mode == 3'(addr_mode_pkg::MODE_IX1)) ? ix1Addr :
                   (mode == 3'(addr_mode_pkg::MODE_IX2)) ? ix2Addr : 16'h0000;

  // pc already points past the branch, offset is sign extended
  assign branchTarget = pc + {{8{byte1[7]}}, byte1};

endmodule : operand_address_unit

// *** rtl/addressing_mode_decoder.sv ***
// instruction fetch, addressing-mode decode and register/memory execution
// Functional notes
// - every opcode maps to one of eight addressing modes; 62-instruction set
// - multiply puts product high byte in index, low byte in accumulator
// - inherent instructions are one opcode byte with no operand address
// - immediate is opcode plus data byte, used directly without memory access
// - direct address is second byte with zero high byte
// - extended address is two bytes, high first then low
// - indexed no offset is one byte, address is index with zero high
// - 8-bit offset sums index and byte with carry kept, two bytes long
// - 16-bit offset adds index to high-then-low offset, three bytes
// - taken branch adds sign-extended offset to program counter past branch
// - untaken branch continues at the next instruction
// - register/memory ops take accumulator or index plus memory operand
// - add, carry add, and, bit, compares, eor, loads, or, subtracts, stores
`timescale 1ns/100ps
module addressing_mode_decoder #(
  parameter logic [15:0] RESET_VECTOR = addr_mode_pkg::RESET_PC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] memRdata,
  output logic [15:0] memAddr,
  output logic memRead,
  output logic memWrite,
  output logic [7:0] memWdata,
  output logic [7:0] accOut,
  output logic [7:0] idxOut,
  output logic [15:0] pcOut,
  output logic carryFlag,
  output logic zeroFlag,
  output logic negFlag,
  output logic instrDone
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic addr_mode_pkg::mode_t modeOf(input logic [7:0] opc);
    logic [3:0] hi;
    hi = opc[7:4];
    if (hi == addr_mode_pkg::HI_REL) modeOf = addr_mode_pkg::MODE_REL;
    else if (hi == addr_mode_pkg::HI_IMM) modeOf = addr_mode_pkg::MODE_IMM;
    else if (hi == addr_mode_pkg::HI_DIR) modeOf = addr_mode_pkg::MODE_DIR;
    else if (hi == addr_mode_pkg::HI_EXT) modeOf = addr_mode_pkg::MODE_EXT;
    else if (hi == addr_mode_pkg::HI_IX2) modeOf = addr_mode_pkg::MODE_IX2;
    else if (hi == addr_mode_pkg::HI_IX1) modeOf = addr_mode_pkg::MODE_IX1;
    else if (hi == addr_mode_pkg::HI_IX) modeOf = addr_mode_pkg::MODE_IX;
    else modeOf = addr_mode_pkg::MODE_INH;
  endfunction : modeOf

  // instruction length in bytes for a mode
  function automatic logic [1:0] lengthOf(input addr_mode_pkg::mode_t m);
    if (m == addr_mode_pkg::MODE_INH || m == addr_mode_pkg::MODE_IX) lengthOf = 2'd1;
    else if (m == addr_mode_pkg::MODE_EXT || m == addr_mode_pkg::MODE_IX2) lengthOf = 2'd3;
    else lengthOf = 2'd2;
  endfunction : lengthOf

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    S_OPC   = 6'b000001,
    S_BYTE1 = 6'b000010,
    S_BYTE2 = 6'b000100,
    S_ADDR  = 6'b001000,
    S_EXEC  = 6'b010000,
    S_STORE = 6'b100000
  } state_t;

  state_t state_q, state_d;
  logic [7:0] opcode_q, byte1_q, byte2_q, acc_q, idx_q, wdata_q;
  logic [15:0] pc_q, addr_q;
  logic rd_q, wr_q, carry_q, zero_q, neg_q, done_q;
  logic [15:0] effAddr, branchTarget;

  // ----------------------------------------------------------------
  // decode of the held opcode and of the byte on memRdata
  // ----------------------------------------------------------------
  addr_mode_pkg::mode_t curMode;
  addr_mode_pkg::mode_t newMode;
  wire [3:0] lowNib = opcode_q[3:0];
  assign curMode = modeOf(opcode_q);
  assign newMode = modeOf(memRdata);
  wire [1:0] newLen = lengthOf(newMode);
  wire [1:0] curLen = lengthOf(curMode);
  wire isStore = (lowNib == addr_mode_pkg::OP_STA) || (lowNib == addr_mode_pkg::OP_STX);
  wire isMemMode = (curMode != addr_mode_pkg::MODE_INH) && (curMode != addr_mode_pkg::MODE_IMM)
                   && (curMode != addr_mode_pkg::MODE_REL);
  wire [15:0] pcInc = pc_q + 16'h0001;

  operand_address_unit eaUnit (
    .mode(3'(curMode)),
    .idx(idx_q),
    .byte1(byte1_q),
    .byte2(byte2_q),
    .pc(pc_q),
    .effAddr(effAddr),
    .branchTarget(branchTarget)
  );

  // ----------------------------------------------------------------
  // branch condition
  // ----------------------------------------------------------------
  wire brTaken = (lowNib == addr_mode_pkg::BR_ALWAYS) ? 1'b1 :
                 (lowNib == addr_mode_pkg::BR_NEVER) ? 1'b0 :
                 (lowNib == addr_mode_pkg::BR_CARRY_CLR) ? !carry_q :
                 (lowNib == addr_mode_pkg::BR_CARRY_SET) ? carry_q :
                 (lowNib == addr_mode_pkg::BR_NOT_EQUAL) ? !zero_q :
                 (lowNib == addr_mode_pkg::BR_EQUAL) ? zero_q :
                 (lowNib == addr_mode_pkg::BR_PLUS) ? !neg_q :
                 (lowNib == addr_mode_pkg::BR_MINUS) ? neg_q : 1'b0;

  // ----------------------------------------------------------------
  // register/memory alu
  // ----------------------------------------------------------------
  // immediate data comes from the instruction, otherwise from memory
  wire [7:0] operand = (curMode == addr_mode_pkg::MODE_IMM) ? byte1_q : memRdata;
  wire useCarry = (lowNib == addr_mode_pkg::OP_ADC) || (lowNib == addr_mode_pkg::OP_SBC);
  wire [8:0] addRes = {1'b0, acc_q} + {1'b0, operand} + {8'h00, useCarry & carry_q};
  wire [8:0] subRes = {1'b0, acc_q} - {1'b0, operand} - {8'h00, useCarry & carry_q};
  wire [8:0] cpxRes = {1'b0, idx_q} - {1'b0, operand};
  wire [15:0] product = {8'h00, acc_q} * {8'h00, idx_q};

  logic [7:0] aluVal;
  logic aluC, wrAcc, wrIdx, hasC, hasNz;
  always_comb begin
    aluVal = 8'h00;
    aluC = 1'b0;
    wrAcc = 1'b0;
    wrIdx = 1'b0;
    hasC = 1'b0;
    hasNz = 1'b1;
    case (lowNib)
      addr_mode_pkg::OP_SUB, addr_mode_pkg::OP_SBC: begin
        aluVal = subRes[7:0];
        aluC = subRes[8];
        wrAcc = 1'b1;
        hasC = 1'b1;
      end
      addr_mode_pkg::OP_CMP: begin
        aluVal = subRes[7:0];
        aluC = subRes[8];
        hasC = 1'b1;
      end
      addr_mode_pkg::OP_CPX: begin
        aluVal = cpxRes[7:0];
        aluC = cpxRes[8];
        hasC = 1'b1;
      end
      addr_mode_pkg::OP_AND: begin
        aluVal = acc_q & operand;
        wrAcc = 1'b1;
      end
      addr_mode_pkg::OP_BIT: aluVal = acc_q & operand;
      addr_mode_pkg::OP_LDA: begin
        aluVal = operand;
        wrAcc = 1'b1;
      end
      addr_mode_pkg::OP_EOR: begin
        aluVal = acc_q ^ operand;
        wrAcc = 1'b1;
      end
      addr_mode_pkg::OP_ADC, addr_mode_pkg::OP_ADD: begin
        aluVal = addRes[7:0];
        aluC = addRes[8];
        wrAcc = 1'b1;
        hasC = 1'b1;
      end
      addr_mode_pkg::OP_ORA: begin
        aluVal = acc_q | operand;
        wrAcc = 1'b1;
      end
      addr_mode_pkg::OP_LDX: begin
        aluVal = operand;
        wrIdx = 1'b1;
      end
      default: hasNz = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_OPC: state_d = (newLen == 2'd1) ? S_ADDR : S_BYTE1;
      S_BYTE1: state_d = (curLen == 2'd3) ? S_BYTE2 : S_ADDR;
      S_BYTE2: state_d = S_ADDR;
      S_ADDR: state_d = !isMemMode ? S_OPC : (isStore ? S_STORE : S_EXEC);
      S_EXEC: state_d = S_OPC;
      S_STORE: state_d = S_OPC;
      default: state_d = S_OPC;
    endcase
  end

  // ----------------------------------------------------------------
  // fetch, address and execute registers
  // ----------------------------------------------------------------
  wire fetchByte = (state_q == S_OPC) || (state_q == S_BYTE1) || (state_q == S_BYTE2);
  wire aluStep = ((state_q == S_ADDR) && (curMode == addr_mode_pkg::MODE_IMM)) ||
                 (state_q == S_EXEC);
  wire inhStep = (state_q == S_ADDR) && (curMode == addr_mode_pkg::MODE_INH);
  wire relStep = (state_q == S_ADDR) && (curMode == addr_mode_pkg::MODE_REL);
  wire memStep = (state_q == S_ADDR) && isMemMode;
  wire [15:0] pcNext = (relStep && brTaken) ? branchTarget : pc_q;
  wire [7:0] incVal = acc_q + 8'h01;
  // byte written by a store, also the source of the store's n and z update
  wire [7:0] storeVal = (lowNib == addr_mode_pkg::OP_STX) ? idx_q : acc_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= S_OPC;
      pc_q <= RESET_VECTOR;
      addr_q <= RESET_VECTOR;
      rd_q <= 1'b1;
      wr_q <= 1'b0;
      wdata_q <= 8'h00;
      opcode_q <= 8'h00;
      byte1_q <= 8'h00;
      byte2_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      done_q <= (state_d == S_OPC) && (state_q != S_OPC);
      if (state_q == S_OPC) opcode_q <= memRdata;
      if (state_q == S_BYTE1) byte1_q <= memRdata;
      if (state_q == S_BYTE2) byte2_q <= memRdata;
      if (fetchByte) begin
        pc_q <= pcInc;
        addr_q <= pcInc;
        rd_q <= 1'b1;
      end else if (memStep) begin
        addr_q <= effAddr;
        rd_q <= !isStore;
        wr_q <= isStore;
        wdata_q <= storeVal;
      end else begin
        pc_q <= pcNext;
        addr_q <= pcNext;
        rd_q <= 1'b1;
        wr_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // cpu registers and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= 8'h00;
      idx_q <= 8'h00;
      carry_q <= 1'b0;
      zero_q <= 1'b0;
      neg_q <= 1'b0;
    end else if (aluStep) begin
      if (wrAcc) acc_q <= aluVal;
      if (wrIdx) idx_q <= aluVal;
      if (hasC) carry_q <= aluC;
      if (hasNz) zero_q <= (aluVal == 8'h00);
      if (hasNz) neg_q <= aluVal[7];
    end else if (memStep && isStore) begin
      zero_q <= (storeVal == 8'h00);
      neg_q <= storeVal[7];
    end else if (inhStep) begin
      if (opcode_q == addr_mode_pkg::UNSIGNED_MULTIPLY_OP) begin
        idx_q <= product[15:8];
        acc_q <= product[7:0];
        carry_q <= 1'b0;
      end else if (opcode_q == addr_mode_pkg::ACCUMULATOR_INCREMENT_OP) begin
        acc_q <= incVal;
        zero_q <= (incVal == 8'h00);
        neg_q <= incVal[7];
      end else if (opcode_q == addr_mode_pkg::CARRY_SET_OP) begin
        carry_q <= 1'b1;
      end else if (opcode_q == addr_mode_pkg::CARRY_CLEAR_OP) begin
        carry_q <= 1'b0;
      end else if (opcode_q == addr_mode_pkg::ACC_TO_IDX_OP) begin
        idx_q <= acc_q;
      end else if (opcode_q == addr_mode_pkg::IDX_TO_ACC_OP) begin
        acc_q <= idx_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign memAddr = addr_q;
  assign memRead = rd_q;
  assign memWrite = wr_q;
  assign memWdata = wdata_q;
  assign accOut = acc_q;
  assign idxOut = idx_q;
  assign pcOut = pc_q;
  assign carryFlag = carry_q;
  assign zeroFlag = zero_q;
  assign negFlag = neg_q;
  assign instrDone = done_q;

endmodule : addressing_mode_decoder

// *** sim/addressing_mode_decoder_properties.sv ***
// port-level checks of the addressing-mode decoder
`timescale 1ns/100ps
module addressing_mode_decoder_properties #(
  parameter logic [15:0] RESET_VECTOR = addr_mode_pkg::RESET_PC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] memRdata,
  input wire logic [15:0] memAddr,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic [7:0] memWdata,
  input wire logic [7:0] accOut,
  input wire logic [7:0] idxOut,
  input wire logic [15:0] pcOut,
  input wire logic carryFlag,
  input wire logic zeroFlag,
  input wire logic negFlag,
  input wire logic instrDone
);
  // ----------------------------------------------------------------
  // opcode fetch qualifiers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic [15:0] offExt = {{8{memRdata[7]}}, memRdata};
  wire logic inhOp = instrDone && !(memRdata[7:4] inside {4'h2, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf});
  sequence s_op(logic [3:0] hi);
    instrDone && memRdata[7:4] == hi;
  endsequence
  a_reset_state: assert property (disable iff (1'b0) sys_rst |=> pcOut == RESET_VECTOR
    && memAddr == RESET_VECTOR && memRead && !memWrite && !instrDone && accOut == 8'h00
    && idxOut == 8'h00) else $error("reset state wrong");
  a_fetch_at_pc: assert property (instrDone |-> memRead && !memWrite && memAddr == pcOut)
    else $error("opcode not fetched at pc");
  a_done_pulse: assert property (instrDone |=> !instrDone) else $error("done too long");
  a_store_pulse: assert property (memWrite |=> !memWrite && instrDone)
    else $error("store pulse wrong");
  a_inherent_len: assert property (inhOp |-> ##2 instrDone && pcOut == $past(pcOut, 2) + 16'h0001)
    else $error("inherent length wrong");
  a_operand_seq: assert property (s_op(addr_mode_pkg::HI_EXT) |=> memAddr == $past(memAddr) + 16'h0001
    ##1 memAddr == $past(memAddr) + 16'h0001) else $error("operand bytes not sequential");
  a_direct_addr: assert property (s_op(addr_mode_pkg::HI_DIR) |-> ##3
    memAddr == {8'h00, $past(memRdata, 2)}) else $error("direct address wrong");
  a_extended_addr: assert property (s_op(addr_mode_pkg::HI_EXT) |-> ##4
    memAddr == {$past(memRdata, 3), $past(memRdata, 2)}) else $error("extended address wrong");
  a_index_addr: assert property (s_op(addr_mode_pkg::HI_IX) |-> ##2
    memAddr == {8'h00, idxOut}) else $error("indexed address wrong");
  a_offset_addr: assert property (s_op(addr_mode_pkg::HI_IX1) |-> ##3
    memAddr == {8'h00, idxOut} + {8'h00, $past(memRdata, 2)}) else $error("offset address wrong");
  a_long_offset: assert property (s_op(addr_mode_pkg::HI_IX2) |-> ##4
    memAddr == {$past(memRdata, 3), $past(memRdata, 2)} + {8'h00, idxOut})
    else $error("long offset address wrong");
  a_branch_taken: assert property (instrDone && memRdata == 8'h20 |-> ##3 instrDone
    && pcOut == $past(pcOut, 3) + 16'h0002 + $past(offExt, 2)) else $error("branch target wrong");
  a_branch_skip: assert property (instrDone && memRdata == 8'h21 |-> ##3 instrDone
    && pcOut == $past(pcOut, 3) + 16'h0002) else $error("untaken branch wrong");
  a_product_split: assert property (instrDone && memRdata == addr_mode_pkg::UNSIGNED_MULTIPLY_OP
    |-> ##2 {idxOut, accOut} == 16'($past(accOut, 2)) * 16'($past(idxOut, 2)) && !carryFlag)
    else $error("product placement wrong");
endmodule : addressing_mode_decoder_properties

bind addressing_mode_decoder addressing_mode_decoder_properties #(.RESET_VECTOR(RESET_VECTOR))
  props_i (.clk(clk), .sys_rst(sys_rst), .memRdata(memRdata), .memAddr(memAddr),
  .memRead(memRead), .memWrite(memWrite), .memWdata(memWdata), .accOut(accOut),
  .idxOut(idxOut), .pcOut(pcOut), .carryFlag(carryFlag), .zeroFlag(zeroFlag),
  .negFlag(negFlag), .instrDone(instrDone));

// *** sim/mem_model.sv ***
// combinational program and data memory seen by the decoder
`timescale 1ns/100ps
module mem_model (
  input wire logic clk,
  input wire logic [15:0] memAddr,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic [7:0] memWdata,
  output logic [7:0] memRdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] lastQ;
  initial begin
    lastQ = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h9d;
    end
  end
  // idle bus shows the inverse of the last byte read
  assign memRdata = memRead ? mem[memAddr] : ~lastQ;
  always @(posedge clk) begin
    if (memRead) begin
      lastQ <= mem[memAddr];
    end
    if (memWrite) begin
      mem[memAddr] <= memWdata;
    end
  end
endmodule : mem_model

// *** sim/tb_top.sv ***
// self-checking bench for the addressing-mode decoder
`timescale 1ns/100ps
module tb_top;
  localparam logic [15:0] PC0 = addr_mode_pkg::RESET_PC;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] memRdata, memWdata, accOut, idxOut;
  logic [15:0] memAddr, pcOut;
  logic memRead, memWrite, carryFlag, zeroFlag, negFlag, instrDone;
  int fails = 0;
  int cmp_count = 0;
  logic [7:0] prog [$];
  always #2.5 clk = ~clk;
  addressing_mode_decoder addressing_mode_decoder_i (.clk(clk), .sys_rst(sys_rst),
    .memRdata(memRdata), .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite),
    .memWdata(memWdata), .accOut(accOut), .idxOut(idxOut), .pcOut(pcOut),
    .carryFlag(carryFlag), .zeroFlag(zeroFlag), .negFlag(negFlag), .instrDone(instrDone));
  mem_model mem_model_i (.clk(clk), .memAddr(memAddr), .memRead(memRead),
    .memWrite(memWrite), .memWdata(memWdata), .memRdata(memRdata));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk
  // program is placed while the core is held in reset
  task automatic boot;
    @(posedge clk);
    sys_rst <= 1'b1;
    for (int i = 0; i < prog.size(); i++) begin
      mem_model_i.mem[PC0 + 16'(i)] = prog[i];
    end
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
  endtask : boot
  task automatic step(input int cyc);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (instrDone !== 1'b1 && n < 20);
    if (instrDone !== 1'b1) begin
      $display("ERROR instrDone expected 1 seen %b", instrDone);
      fails++;
      stop_test();
    end else if (cyc != 0) begin
      chk("cycles", 16'(cyc), 16'(n));
    end
  endtask : step
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic sc_immediate;
    prog = '{8'ha6, 8'h35, 8'hab, 8'h4a, 8'h99, 8'ha9, 8'h00, 8'hae, 8'h5a};
    boot();
    #1;
    chk("reset pc", PC0, pcOut);
    step(3);
    step(3);
    chk("add acc", 16'h007f, {8'h00, accOut});
    step(2);
    step(3);
    chk("adc acc", 16'h0080, {8'h00, accOut});
    step(3);
    chk("ldx idx", 16'h005a, {8'h00, idxOut});
    chk("pc", PC0 + 16'h0009, pcOut);
  endtask : sc_immediate
  task automatic sc_alu_ops;
    logic [7:0] ops [11] = '{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha8, 8'ha9, 8'haa,
      8'hab};
    logic [7:0] res [11] = '{8'h87, 8'hc3, 8'h87, 8'hc3, 8'h00, 8'hc3, 8'h3c, 8'hff, 8'hff, 8'hff,
      8'hff};
    // zero flag in bit 1, carry in bit 0
    logic [1:0] zc [11] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
    for (int i = 0; i < 11; i++) begin
      prog = '{8'ha6, 8'hc3, ops[i], 8'h3c};
      boot();
      step(3);
      step(3);
      chk("alu acc", {8'h00, res[i]}, {8'h00, accOut});
      chk("alu flags", {14'h0000, zc[i]}, {14'h0000, zeroFlag, carryFlag});
    end
  endtask : sc_alu_ops
  task automatic sc_direct_ext;
    mem_model_i.mem[16'h0040] = 8'h5c;
    mem_model_i.mem[16'h0140] = 8'he1;
    mem_model_i.mem[16'h3a7c] = 8'h91;
    prog = '{8'hb6, 8'h40, 8'hb7, 8'h41, 8'hae, 8'h77, 8'hbf, 8'h42, 8'hc6, 8'h3a, 8'h7c};
    boot();
    step(4);
    chk("dir acc", 16'h005c, {8'h00, accOut});
    step(4);
    step(3);
    step(4);
    chk("sta mem", 16'h005c, {8'h00, mem_model_i.mem[16'h0041]});
    chk("stx mem", 16'h0077, {8'h00, mem_model_i.mem[16'h0042]});
    step(5);
    chk("ext acc", 16'h0091, {8'h00, accOut});
    chk("ext neg", 16'h0001, {15'h0000, negFlag});
  endtask : sc_direct_ext
  task automatic sc_indexed;
    mem_model_i.mem[16'h0080] = 8'h11;
    mem_model_i.mem[16'h0180] = 8'h22;
    mem_model_i.mem[16'h01fe] = 8'h33;
    mem_model_i.mem[16'h00fe] = 8'h44;
    mem_model_i.mem[16'h000f] = 8'h55;
    prog = '{8'hae, 8'h80, 8'hf6, 8'hae, 8'hff, 8'he6, 8'hff, 8'hd6, 8'hff, 8'h10};
    boot();
    step(3);
    step(3);
    chk("ix acc", 16'h0011, {8'h00, accOut});
    step(3);
    step(4);
    chk("ix1 acc", 16'h0033, {8'h00, accOut});
    step(5);
    chk("ix2 acc", 16'h0055, {8'h00, accOut});
  endtask : sc_indexed
  task automatic sc_multiply;
    prog = '{8'ha6, 8'h12, 8'hae, 8'h34, 8'h42, 8'h4c, 8'h97};
    boot();
    step(3);
    step(3);
    step(2);
    chk("product high", 16'h0003, {8'h00, idxOut});
    chk("product low", 16'h00a8, {8'h00, accOut});
    step(2);
    chk("inc acc", 16'h00a9, {8'h00, accOut});
    step(2);
    chk("xfer idx", 16'h00a9, {8'h00, idxOut});
    chk("pc", PC0 + 16'h0007, pcOut);
  endtask : sc_multiply
  task automatic sc_branch;
    prog = '{8'h99, 8'h20, 8'h05, 8'h9d, 8'h9d, 8'h9d, 8'h9d, 8'h9d,
      8'h21, 8'h7f, 8'h24, 8'h10, 8'h25, 8'h80};
    // equal and plus branches placed at the backward target
    mem_model_i.mem[16'h008e] = 8'h27;
    mem_model_i.mem[16'h008f] = 8'h02;
    mem_model_i.mem[16'h0090] = 8'h2a;
    mem_model_i.mem[16'h0091] = 8'h10;
    boot();
    step(2);
    step(3);
    chk("bra pc", PC0 + 16'h0008, pcOut);
    step(3);
    chk("brn pc", PC0 + 16'h000a, pcOut);
    step(3);
    chk("bcc pc", PC0 + 16'h000c, pcOut);
    step(3);
    chk("bcs pc", 16'h008e, pcOut);
    step(3);
    chk("beq pc", 16'h0090, pcOut);
    step(3);
    chk("bpl pc", 16'h00a2, pcOut);
  endtask : sc_branch
  initial begin
    sc_immediate();
    sc_alu_ops();
    sc_direct_ext();
    sc_indexed();
    sc_multiply();
    sc_branch();
    stop_test();
  end
endmodule : tb_top
